// ==== include/pcmvs_pkg.sv ====
// Purpose: constants and types of the PCM voice slot interface
// Assumes: sys_clk at 50 MHz, interface rate given in kHz of bit clock
// Notes: configuration travels as one 32-bit word, fields below
//
// Overview of operation
// - master drives clock and sync, slave receives
// - three duplex channels, each on any of slots 0 to 15
// - 8 kHz: slots equal rate divided by 128
// - 16 kHz: slots equal rate divided by 256
// - transmit and receive share one slot
// - data output floats on unowned slots
// - release after falling edge of last bit
// - transparent wideband: 4 kHz, 16-bit, unchanged
// - on-chip codec: linear 16-bit at 16 kHz
// - short or long sync, master or slave
// - short sync: one bit, high, rising aligned
// - short slave: sync on fall, slot next rise
// - long sync: three bits, starts with bit zero
// - 13 sample bits, placement and order configurable
// - fill bits ignored in, filled out as configured
// - reset format: left justified, msb first
// - shared voice buffer holds 1040 bytes
// - settings load from command or config file
package pcmvs_pkg;
   // ************************************************************
   // clocking and sizes
   // ************************************************************
   localparam int SYS_CLK_KHZ = 50000;
   localparam int BASE_RATE_KHZ = 128;
   localparam int NUM_CH = 3;
   localparam int SLOT_BITS = 16;
   localparam int SAMPLE_BITS = 13;
   localparam int FILL_BITS = 3;
   localparam int LONG_SYNC_BITS = 3;
   localparam int VOICE_BUF_BYTES = 1040;
   localparam int MAX_RATE_SEL = 4;
   localparam int CNT_W = 10;

   // ************************************************************
   // configuration word layout
   // ************************************************************
   localparam int CFG_MASTER_POS = 0;
   localparam int CFG_LONG_POS = 1;
   localparam int CFG_RATE_POS = 2;
   localparam int CFG_FRATE_POS = 5;
   localparam int CFG_MODE_POS = 7;
   localparam int CFG_RJUST_POS = 9;
   localparam int CFG_LSBF_POS = 10;
   localparam int CFG_FILL_POS = 11;
   localparam int CFG_FVAL_POS = 13;
   localparam int CFG_EN_POS = 16;
   localparam int CFG_CHEN_POS = 17;
   localparam int CFG_SLOT0_POS = 20;
   localparam int CFG_SLOT_W = 4;
   localparam logic [31:0] CFG_RESET = 32'h2100_0000;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {FR_8K, FR_16K, FR_4K} pcmvs_frate_t;
   typedef enum logic [1:0] {VM_NARROW, VM_TRANSPARENT, VM_CODEC} pcmvs_mode_t;
   typedef enum logic [1:0] {FILL_ZERO, FILL_ONE, FILL_SIGN, FILL_VALUE} pcmvs_fill_t;
   typedef enum logic [1:0] {LK_IDLE, LK_HUNT, LK_RUN} pcmvs_lock_t;
endpackage

// ==== verilog/pcmvs_pin_sync.sv ====
// Purpose: three-stage synchroniser for a pin level
// Assumes: input asynchronous to sys_clk
// Notes: level changes only once stages two and three agree
`timescale 1ns/1ps
module pcmvs_pin_sync
   import pcmvs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic pinIn,
   output logic pinLevel
);
   logic st1_q;
   logic st2_q;
   logic st3_q;
   logic level_q;
   wire agree = (st2_q == st3_q);

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         st1_q <= 1'b0;
         st2_q <= 1'b0;
         st3_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         st1_q <= pinIn;
         st2_q <= st1_q;
         st3_q <= st2_q;
         if (agree) begin
            level_q <= st3_q;
         end
      end
   end

   assign pinLevel = level_q;
endmodule // pcmvs_pin_sync

// ==== verilog/pcmvs_voice_slot.sv ====
// Purpose: time-slotted PCM voice port with three duplex channels
// Assumes: slave bit clock well below sys_clk / 6
// Notes: a configuration load restarts framing
`timescale 1ns/1ps
module pcmvs_voice_slot
   import pcmvs_pkg::*;
#(
   parameter int BUF_BYTES = VOICE_BUF_BYTES
)(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic cmdLoad,
   input wire logic [31:0] cmdCfg,
   input wire logic fileLoad,
   input wire logic [31:0] fileCfg,
   input wire logic [NUM_CH-1:0][SLOT_BITS-1:0] chTxData,
   output logic txTake,
   output logic [NUM_CH-1:0][SLOT_BITS-1:0] chRxData,
   output logic [NUM_CH-1:0] chRxValid,
   input wire logic bclkIn,
   output logic bclkOut,
   output logic bclkOe,
   input wire logic syncIn,
   output logic syncOut,
   output logic syncOe,
   input wire logic dinPin,
   output logic doutPin,
   output logic doutOe,
   output logic [5:0] numSlots,
   output logic frameLock,
   output logic cfgBad
);
   // ************************************************************
   // elaboration checks
   // ************************************************************
   if (BUF_BYTES < VOICE_BUF_BYTES) begin : g_buf_chk
      $error("voice buffer smaller than one full packet payload");
   end

   // ************************************************************
   // configuration
   // ************************************************************
   logic [31:0] cfg_q;
   wire anyLoad = cmdLoad | fileLoad;
   wire [31:0] cfgNew = cmdLoad ? cmdCfg : fileCfg;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cfg_q <= CFG_RESET;
      end else if (anyLoad) begin
         cfg_q <= cfgNew;
      end
   end

   wire cfgMaster = cfg_q[CFG_MASTER_POS];
   wire cfgLong = cfg_q[CFG_LONG_POS];
   wire [2:0] rateSel = cfg_q[CFG_RATE_POS +: 3];
   wire [1:0] frRaw = cfg_q[CFG_FRATE_POS +: 2];
   wire [1:0] modeRaw = cfg_q[CFG_MODE_POS +: 2];
   wire cfgRjust = cfg_q[CFG_RJUST_POS];
   wire cfgLsbf = cfg_q[CFG_LSBF_POS];
   wire [1:0] fillRaw = cfg_q[CFG_FILL_POS +: 2];
   wire [2:0] fillVal = cfg_q[CFG_FVAL_POS +: FILL_BITS];
   wire cfgEn = cfg_q[CFG_EN_POS];
   wire [NUM_CH-1:0] chEn = cfg_q[CFG_CHEN_POS +: NUM_CH];
   wire [NUM_CH*CFG_SLOT_W-1:0] chSlots = cfg_q[CFG_SLOT0_POS +: NUM_CH*CFG_SLOT_W];

   // ************************************************************
   // frame geometry
   // ************************************************************
   wire pcmvs_mode_t vMode = pcmvs_mode_t'(modeRaw);
   wire pcmvs_fill_t fillMode = pcmvs_fill_t'(fillRaw);
   wire pcmvs_frate_t effFr = (vMode == VM_TRANSPARENT) ? FR_4K :
                              (vMode == VM_CODEC) ? FR_16K :
                              pcmvs_frate_t'(frRaw);
   wire rawFmt = (vMode != VM_NARROW);
   wire [CNT_W-1:0] bits8k = CNT_W'(16) << rateSel;
   wire [CNT_W-1:0] bits16k = CNT_W'(8) << rateSel;
   wire [CNT_W-1:0] bits4k = CNT_W'(32) << rateSel;
   wire [CNT_W-1:0] frameBits = (effFr == FR_16K) ? bits16k :
                                (effFr == FR_4K) ? bits4k : bits8k;
   wire [CNT_W-1:0] frameLast = frameBits - CNT_W'(1);
   wire badRate = (rateSel > 3'(MAX_RATE_SEL)) || (frRaw == 2'd3) || (modeRaw == 2'd3);
   wire bad16 = (effFr == FR_16K) && (rateSel == 3'd0);
   wire runOk = cfgEn && !badRate && !bad16;
   assign numSlots = 6'(frameBits >> 4);
   assign cfgBad = badRate | bad16;

   // ************************************************************
   // functions
   // ************************************************************
   function automatic logic [7:0] halfDiv(input logic [2:0] sel);
      case (sel)
         3'd0: halfDiv = 8'(SYS_CLK_KHZ / (BASE_RATE_KHZ * 2));
         3'd1: halfDiv = 8'(SYS_CLK_KHZ / (BASE_RATE_KHZ * 4));
         3'd2: halfDiv = 8'(SYS_CLK_KHZ / (BASE_RATE_KHZ * 8));
         3'd3: halfDiv = 8'(SYS_CLK_KHZ / (BASE_RATE_KHZ * 16));
         default: halfDiv = 8'(SYS_CLK_KHZ / (BASE_RATE_KHZ * 32));
      endcase
   endfunction

   // owner lookup: bit 2 hit, bits 1:0 channel, lowest channel wins
   function automatic logic [2:0] ownerOf(input logic [CNT_W-1:0] cnt,
                                           input logic [NUM_CH-1:0] en,
                                           input logic [NUM_CH*CFG_SLOT_W-1:0] slots);
      logic [5:0] slot;
      slot = 6'(cnt >> 4);
      ownerOf = 3'b000;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (en[i] && (slot == 6'(slots[i*CFG_SLOT_W +: CFG_SLOT_W]))) begin
            ownerOf = {1'b1, 2'(i)};
         end
      end
   endfunction

   function automatic logic [15:0] fmtTx(input logic [15:0] smp);
      logic [2:0] fill;
      fill = 3'b000;
      case (fillMode)
         FILL_ZERO: fill = 3'b000;
         FILL_ONE: fill = 3'b111;
         FILL_SIGN: fill = {3{smp[SAMPLE_BITS-1]}};
         default: fill = fillVal;
      endcase
      if (rawFmt) begin
         fmtTx = smp;
      end else if (cfgRjust) begin
         fmtTx = {fill, smp[SAMPLE_BITS-1:0]};
      end else begin
         fmtTx = {smp[SAMPLE_BITS-1:0], fill};
      end
   endfunction

   function automatic logic [15:0] fmtRx(input logic [15:0] w);
      logic [12:0] s;
      s = cfgRjust ? w[SAMPLE_BITS-1:0] : w[15:FILL_BITS];
      fmtRx = rawFmt ? w : {{FILL_BITS{s[SAMPLE_BITS-1]}}, s};
   endfunction

   // ************************************************************
   // pin synchronisers and bit clock edges
   // ************************************************************
   logic bclkS;
   logic syncS;
   logic dinS;

   pcmvs_pin_sync u_bclk (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .pinIn(bclkIn),
      .pinLevel(bclkS)
   );
   pcmvs_pin_sync u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .pinIn(syncIn),
      .pinLevel(syncS)
   );
   pcmvs_pin_sync u_din (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .pinIn(dinPin),
      .pinLevel(dinS)
   );

   logic [7:0] divCnt_q;
   logic bclkGen_q;
   logic bclkPrev_q;
   pcmvs_lock_t lock_q;
   pcmvs_lock_t lock_d;
   wire mRun = cfgMaster && runOk && (lock_q == LK_RUN);
   wire divWrap = (divCnt_q == 8'h00);
   wire mRise = mRun && divWrap && !bclkGen_q;
   wire mFall = mRun && divWrap && bclkGen_q;
   wire sRise = !cfgMaster && runOk && bclkS && !bclkPrev_q;
   wire sFall = !cfgMaster && runOk && !bclkS && bclkPrev_q;
   wire riseEv = cfgMaster ? mRise : sRise;
   wire fallEv = cfgMaster ? mFall : sFall;

   always_ff @(posedge sys_clk) begin
      if (!rstn || !mRun) begin
         divCnt_q <= 8'h00;
         bclkGen_q <= 1'b0;
      end else if (divWrap) begin
         divCnt_q <= halfDiv(rateSel) - 8'h01;
         bclkGen_q <= !bclkGen_q;
      end else begin
         divCnt_q <= divCnt_q - 8'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         bclkPrev_q <= 1'b0;
      end else begin
         bclkPrev_q <= bclkS;
      end
   end

   // ************************************************************
   // framing
   // ************************************************************
   logic [CNT_W-1:0] bitCnt_q;
   logic [CNT_W-1:0] bitCnt_d;
   logic pendStart_q;
   logic syncFallPrev_q;
   wire shortHit = fallEv && syncS && !cfgLong;
   wire longHit = fallEv && syncS && !syncFallPrev_q && cfgLong;
   wire [CNT_W-1:0] nextCnt = pendStart_q ? '0 :
                              (bitCnt_q == frameLast) ? '0 : bitCnt_q + CNT_W'(1);
   wire [3:0] curBit = bitCnt_q[3:0];
   wire [3:0] curPos = cfgLsbf ? curBit : 4'd15 - curBit;
   wire [3:0] nxtPos = cfgLsbf ? nextCnt[3:0] : 4'd15 - nextCnt[3:0];
   wire [2:0] txOwn = ownerOf(nextCnt, chEn, chSlots);
   wire [2:0] rxOwn = ownerOf(bitCnt_q, chEn, chSlots);
   wire lastBit = (curBit == 4'd15);
   wire inRun = (lock_q == LK_RUN);

   always_comb begin
      lock_d = lock_q;
      bitCnt_d = bitCnt_q;
      case (lock_q)
         LK_IDLE: begin
            bitCnt_d = frameLast;
            if (runOk) begin
               lock_d = cfgMaster ? LK_RUN : LK_HUNT;
            end
         end
         LK_HUNT: begin
            if (shortHit || longHit) begin
               lock_d = LK_RUN;
            end
            if (longHit) begin
               bitCnt_d = '0;
            end
         end
         LK_RUN: begin
            if (riseEv) begin
               bitCnt_d = nextCnt;
            end else if (longHit) begin
               bitCnt_d = '0;
            end
         end
         default: lock_d = LK_IDLE;
      endcase
      if (!runOk || anyLoad) begin
         lock_d = LK_IDLE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         lock_q <= LK_IDLE;
         bitCnt_q <= '0;
         pendStart_q <= 1'b0;
         syncFallPrev_q <= 1'b0;
      end else begin
         lock_q <= lock_d;
         bitCnt_q <= bitCnt_d;
         if (shortHit) begin
            pendStart_q <= 1'b1;
         end else if (riseEv || lock_d == LK_IDLE) begin
            pendStart_q <= 1'b0;
         end
         if (fallEv) begin
            syncFallPrev_q <= syncS;
         end
      end
   end

   assign frameLock = inRun;

   // ************************************************************
   // master frame sync
   // ************************************************************
   logic syncGen_q;
   wire syncNext = cfgLong ? (nextCnt < CNT_W'(LONG_SYNC_BITS)) : (nextCnt == frameLast);

   always_ff @(posedge sys_clk) begin
      if (!rstn || !mRun) begin
         syncGen_q <= 1'b0;
      end else if (mRise) begin
         syncGen_q <= syncNext;
      end
   end

   assign bclkOut = bclkGen_q;
   assign syncOut = syncGen_q;
   assign bclkOe = cfgMaster && runOk;
   assign syncOe = cfgMaster && runOk;

   // ************************************************************
   // transmit
   // ************************************************************
   logic [NUM_CH-1:0][SLOT_BITS-1:0] txWord_q;
   logic dout_q;
   logic doutOe_q;
   logic txTake_q;
   wire latchTx = inRun && riseEv && (nextCnt == frameLast);

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         txWord_q <= '0;
         txTake_q <= 1'b0;
      end else begin
         txTake_q <= latchTx;
         if (latchTx) begin
            for (int i = 0; i < NUM_CH; i++) begin
               txWord_q[i] <= fmtTx(chTxData[i]);
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn || !inRun) begin
         dout_q <= 1'b0;
         doutOe_q <= 1'b0;
      end else if (riseEv) begin
         doutOe_q <= txOwn[2];
         dout_q <= txOwn[2] ? txWord_q[txOwn[1:0]][nxtPos] : 1'b0;
      end else if (fallEv && lastBit) begin
         doutOe_q <= 1'b0;
      end
   end

   assign doutPin = dout_q;
   assign doutOe = doutOe_q;
   assign txTake = txTake_q;

   // ************************************************************
   // receive
   // ************************************************************
   logic [SLOT_BITS-1:0] rxShift_q;
   logic [NUM_CH-1:0][SLOT_BITS-1:0] rxData_q;
   logic [NUM_CH-1:0] rxValid_q;
   logic [SLOT_BITS-1:0] rxAsm;

   always_comb begin
      rxAsm = rxShift_q;
      rxAsm[curPos] = dinS;
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rxShift_q <= '0;
         rxData_q <= '0;
         rxValid_q <= '0;
      end else begin
         rxValid_q <= '0;
         if (inRun && fallEv && rxOwn[2]) begin
            rxShift_q <= rxAsm;
            if (lastBit) begin
               rxData_q[rxOwn[1:0]] <= fmtRx(rxAsm);
               rxValid_q[rxOwn[1:0]] <= 1'b1;
            end
         end
      end
   end

   assign chRxData = rxData_q;
   assign chRxValid = rxValid_q;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence s_master_rise;
      mRise && !cfgLong;
   endsequence
   sequence s_short_start;
      syncGen_q && bitCnt_q == frameLast;
   endsequence

   chk_master_drive: assert property (cfgMaster && runOk |-> bclkOe && syncOe)
      else $error("master not driving clock and sync");
   chk_slave_float: assert property (!cfgMaster |-> !bclkOe && !syncOe)
      else $error("slave driving clock or sync");
   chk_slots_8k: assert property (effFr == FR_8K |-> numSlots == 6'(1 << rateSel))
      else $error("8 kHz slot count wrong");
   chk_slots_16k: assert property (effFr == FR_16K && rateSel != 0
                                   |-> numSlots == 6'(1 << (rateSel - 1)))
      else $error("16 kHz slot count wrong");
   chk_unused_float: assert property (riseEv && inRun && !txOwn[2] |=> !doutOe)
      else $error("data driven on unowned slot");
   chk_release_last: assert property (inRun && fallEv && lastBit |=> !doutOe)
      else $error("data not released after last bit");
   chk_short_width: assert property (s_master_rise ##0 syncNext |=> s_short_start)
      else $error("short sync not on last bit");
   chk_short_drop: assert property ($fell(syncGen_q) && $past(mRise) && !cfgLong
                                    |-> bitCnt_q == '0)
      else $error("short sync wider than one bit");
   chk_long_width: assert property ($fell(syncGen_q) && $past(mRise) && cfgLong
                                    |-> bitCnt_q == CNT_W'(LONG_SYNC_BITS))
      else $error("long sync not three bits");
   chk_slave_start: assert property (pendStart_q && riseEv && inRun |=> bitCnt_q == '0)
      else $error("slot zero not after sync");
   chk_reset_format: assert property ($past(!rstn) && !anyLoad |-> !cfgRjust && !cfgLsbf)
      else $error("reset format not left msb first");
   chk_fill_zero: assert property (latchTx && !rawFmt && !cfgRjust && fillMode == FILL_ZERO
                                   |=> txWord_q[0][2:0] == 3'b000)
      else $error("fill bits not zero");
endmodule // pcmvs_voice_slot

// ==== testbench/pcmvs_codec_model.sv ====
// Purpose: behavioural linear pcm codec on the far side of the voice port
// Assumes: one slot of interest, 16-bit slots, bit clock from either side
// Notes: drives the 160 ns bit clock and sync only when it is the master
`timescale 1ns/1ps
module pcmvs_codec_model (
   input wire logic bclkWire,
   input wire logic syncWire,
   input wire logic drvMaster,
   input wire logic longSync,
   input wire logic [9:0] frameBits,
   input wire logic [3:0] slot,
   input wire logic [15:0] txPat,
   input wire logic doutPin,
   input wire logic doutOe,
   output logic bclkDrv,
   output logic syncDrv,
   output logic din,
   output logic [15:0] word,
   output logic [15:0] wordCnt,
   output logic [7:0] oeBad
);
   int bitCnt = 0;
   bit aligned = 0;
   bit prevSync = 0;
   logic [15:0] shift = 16'h0000;
   wire inSlot = aligned && ((bitCnt >> 4) == int'(slot));
   initial begin
      bclkDrv = 1'b0;
      syncDrv = 1'b0;
      din = 1'b0;
      word = 16'h0000;
      wordCnt = 16'h0000;
      oeBad = 8'h00;
   end
   // ****************
   // framing
   // ****************
   always begin
      #80;
      bclkDrv = drvMaster ? ~bclkDrv : 1'b0;
   end
   always @(posedge bclkWire) begin
      bitCnt = (bitCnt + 1) % int'(frameBits);
      syncDrv = drvMaster && (longSync ? bitCnt < 3 : bitCnt == int'(frameBits) - 1);
      din = (aligned && (bitCnt >> 4) == int'(slot)) ? txPat[15 - bitCnt % 16] : ~din;
   end
   always @(negedge bclkWire) begin
      if (!longSync && syncWire)
         bitCnt = int'(frameBits) - 1;
      if (longSync && syncWire && !prevSync)
         bitCnt = 0;
      aligned |= syncWire;
      prevSync = syncWire;
   end
   // ****************
   // capture and output enable watch
   // ****************
   always @(posedge bclkWire) begin
      #40;
      if (inSlot) begin
         shift = {shift[14:0], doutPin};
         if (!drvMaster && !doutOe)
            oeBad++;
         if (bitCnt % 16 == 15) begin
            word = shift;
            wordCnt++;
         end
      end else if (aligned && !drvMaster && doutOe)
         oeBad++;
   end
endmodule // pcmvs_codec_model

// ==== testbench/tb.sv ====
// Purpose: self-checking bench of the pcm voice slot port
// Assumes: codec model on the far side, 50 MHz system clock
// Notes: expected words are queued by the driver and popped by monitors
`timescale 1ns/1ps
module tb;
   import pcmvs_pkg::*;
   logic sysClk = 1'b0;
   logic rstn = 1'b0;
   logic cmdLoad = 1'b0;
   logic fileLoad = 1'b0;
   logic [31:0] cmdCfg = 32'h0000_0000;
   logic [31:0] fileCfg = 32'h0000_0000;
   logic [NUM_CH-1:0][SLOT_BITS-1:0] chTx = '0;
   logic [NUM_CH-1:0][SLOT_BITS-1:0] chRx;
   logic [NUM_CH-1:0] chRxValid;
   logic [5:0] numSlots;
   logic txTake, bclkOut, bclkOe, syncOut, syncOe, doutPin, doutOe, frameLock, cfgBad;
   logic bclkDrv, syncDrv, din, drvMaster = 1'b0, longSync = 1'b0;
   logic [9:0] frameBits = 10'h010;
   logic [3:0] slot = 4'h0;
   logic [15:0] txPat = 16'h0000;
   logic [15:0] word, wordCnt;
   logic [7:0] oeBad;
   wire bclkWire = bclkOe ? bclkOut : bclkDrv;
   wire syncWire = syncOe ? syncOut : syncDrv;
   int numErrors = 0;
   int comparisons = 0;
   int curCh = 0;
   int takes = 0;
   logic [15:0] txQ[$];
   logic [15:0] rxQ[$];
   pcmvs_voice_slot dut (.sys_clk(sysClk), .rstn(rstn), .cmdLoad(cmdLoad), .cmdCfg(cmdCfg),
      .fileLoad(fileLoad), .fileCfg(fileCfg), .chTxData(chTx), .txTake(txTake),
      .chRxData(chRx), .chRxValid(chRxValid), .bclkIn(bclkWire), .bclkOut(bclkOut),
      .bclkOe(bclkOe), .syncIn(syncWire), .syncOut(syncOut), .syncOe(syncOe), .dinPin(din),
      .doutPin(doutPin), .doutOe(doutOe), .numSlots(numSlots), .frameLock(frameLock),
      .cfgBad(cfgBad));
   pcmvs_codec_model codec (.bclkWire(bclkWire), .syncWire(syncWire), .drvMaster(drvMaster),
      .longSync(longSync), .frameBits(frameBits), .slot(slot), .txPat(txPat),
      .doutPin(doutPin), .doutOe(doutOe), .bclkDrv(bclkDrv), .syncDrv(syncDrv), .din(din),
      .word(word), .wordCnt(wordCnt), .oeBad(oeBad));
   initial begin
      forever #10 sysClk = ~sysClk;
   end
   // ****************
   // helpers
   // ****************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         numErrors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic printVerdict;
      $display("comparisons %0d mismatches %0d", comparisons, numErrors);
      if (numErrors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   function automatic logic [15:0] rev(input logic [15:0] w);
      for (int i = 0; i < 16; i++)
         rev[i] = w[15 - i];
   endfunction
   function automatic logic [31:0] mk(input int m, lg, rs, fr, md, rj, lb, fm, fv, ch, sl);
      return {sl[3:0], sl[3:0], sl[3:0], 3'(1 << ch), 1'b1, fv[2:0], fm[1:0], lb[0], rj[0],
         md[1:0], fr[1:0], rs[2:0], lg[0], m[0]};
   endfunction
   task automatic load(input logic [31:0] c, input bit viaFile);
      @(negedge sysClk);
      if (viaFile) begin
         fileCfg = c;
         fileLoad = 1'b1;
      end else begin
         cmdCfg = c;
         cmdLoad = 1'b1;
      end
      @(negedge sysClk);
      fileLoad = 1'b0;
      cmdLoad = 1'b0;
   endtask
   task automatic waitQuiet(input int n);
      logic [15:0] start;
      int k;
      start = wordCnt;
      for (k = 0; k < 20000; k++) begin
         if (16'(wordCnt - start) >= 16'(n) && txQ.size() == 0 && rxQ.size() == 0)
            break;
         @(negedge sysClk);
      end
      if (k == 20000) begin
         numErrors++;
         $display("unexpected at %0t: no frame traffic", $time);
         printVerdict();
      end
   endtask
   // ****************
   // one framed transfer per configuration
   // ****************
   task automatic runVariant(input int m, lg, rs, md, rj, lb, fm, fv, ch, sl, fb);
      logic [15:0] s, w, f;
      int base;
      int tk;
      @(negedge sysClk);
      chTx = {16'($urandom), 16'($urandom), 16'($urandom)};
      txPat = 16'($urandom);
      curCh = ch;
      slot = 4'(sl);
      longSync = lg[0];
      drvMaster = !m[0];
      frameBits = 10'(fb);
      load(mk(m, lg, rs, m, md, rj, lb, fm, fv, ch, sl), ch[0]);
      waitQuiet(m ? 2 : 4);
      base = oeBad;
      tk = takes;
      s = chTx[ch];
      f = fm == 0 ? 16'h0000 : fm == 1 ? 16'h0007 : fm == 2 ? {13'h0000, {3{s[12]}}} : 16'(fv);
      w = md != 0 ? s : rj ? {f[2:0], s[12:0]} : {s[12:0], f[2:0]};
      if (m)
         txQ.push_back(lb ? rev(w) : w);
      w = lb ? rev(txPat) : txPat;
      rxQ.push_back(md != 0 ? w : rj ? {{3{w[12]}}, w[12:0]} : {{3{w[15]}}, w[15:3]});
      waitQuiet(1);
      check(16'(oeBad), 16'(base));
      check(16'(bclkOe), 16'(m));
      check(16'(syncOe), 16'(m));
      check(16'(frameLock), 16'h0001);
      check(16'(takes != tk), 16'h0001);
      $display("test done: master %0d long %0d mode %0d ch %0d slot %0d", m, lg, md, ch, sl);
   endtask
   // ****************
   // monitors
   // ****************
   always @(wordCnt)
      if (txQ.size() > 0)
         check(word, txQ.pop_front());
   always @(negedge sysClk)
      if (txTake === 1'b1)
         takes++;
   always @(negedge sysClk)
      if (chRxValid[curCh] === 1'b1 && rxQ.size() > 0)
         check(chRx[curCh], rxQ.pop_front());
   // ****************
   // main sequence
   // ****************
   initial begin
      bit bad;
      void'($urandom(32'he96d));
      repeat (16) @(negedge sysClk);
      rstn = 1'b1;
      @(negedge sysClk);
      check(16'(numSlots), 16'h0001);
      check(16'(cfgBad), 16'h0000);
      check(16'(bclkOe), 16'h0000);
      check(16'(doutOe), 16'h0000);
      $display("test done: reset state");
      for (int fr = 0; fr < 2; fr++)
         for (int rs = 0; rs < 6; rs++) begin
            load(mk(0, 0, rs, fr, 0, 0, 0, 0, 0, 0, 0), 1'b0);
            @(negedge sysClk);
            bad = rs > 4 || (fr == 1 && rs == 0);
            check(16'(cfgBad), 16'(bad));
            if (!bad)
               check(16'(numSlots), 16'(1 << (rs - fr)));
         end
      $display("test done: slot table");
      runVariant(1, 0, 2, 0, 0, 0, 0, 0, 0, 0, 32);
      runVariant(1, 0, 2, 0, 1, 1, 1, 0, 1, 1, 32);
      runVariant(1, 1, 2, 0, 0, 1, 2, 0, 2, 1, 32);
      runVariant(1, 1, 2, 0, 1, 0, 3, 5, 0, 0, 32);
      runVariant(1, 0, 2, 2, 0, 0, 0, 0, 1, 1, 32);
      runVariant(0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 16);
      runVariant(0, 1, 0, 0, 0, 0, 2, 0, 1, 0, 16);
      printVerdict();
   end
endmodule // tb
